// >>> rtl/tsc_pkg.sv
// Package for the timer section control block: offsets, fields, types
package tsc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RUN_CTL = 8'h0e;
  localparam logic [7:0] OFS_T0_CFG = 8'h0f;
  localparam logic [7:0] OFS_T0_RLD_HI = 8'h10;
  localparam logic [7:0] OFS_T0_RLD_LO = 8'h11;
  localparam logic [7:0] OFS_T0_CNT_HI = 8'h12;
  localparam logic [7:0] OFS_T0_CNT_LO = 8'h13;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int RUN_BIT_LSB = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_RW_MASK = 8'hbb;
  localparam logic [7:0] RLD_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing: 211.875 kHz tick is the 13.56 MHz base divided by 64
  // ----------------------------------------------------------------
  localparam int PRESC_DIV = 64;
  localparam logic [5:0] PRESC_LAST = 6'(PRESC_DIV - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    START_NONE = 2'b00,
    START_TX_END = 2'b01,
    START_TRIM_NO_UF = 2'b10,
    START_TRIM_UF = 2'b11
  } tsc_start_mode_t;

  typedef enum logic [1:0] {
    TICK_BASE = 2'b00,
    TICK_DIV64 = 2'b01,
    TICK_T2_UF = 2'b10,
    TICK_T1_UF = 2'b11
  } tsc_tick_sel_t;

  typedef enum logic {
    T0_IDLE = 1'b0,
    T0_RUN = 1'b1
  } tsc_t0_state_t;

  typedef struct packed {
    logic stop_on_first_rx_bits;
    logic rsv6;
    tsc_start_mode_t auto_start_mode;
    logic reload_on_zero;
    logic rsv2;
    tsc_tick_sel_t tick_source_select;
  } tsc_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsc_reg_req_t;

endpackage

// >>> rtl/tsc_timer_section.sv
// Timer section run control plus the complete first timer
`timescale 1ns/1ps
`default_nettype none

module tsc_timer_section (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Host register port
  input var tsc_pkg::tsc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Link events, one-cycle pulses
  input wire logic tx_end,
  input wire logic rx_first_bits,
  input wire logic lfo_rise,
  // Neighbouring timers
  input wire logic timer_one_underflow,
  input wire logic timer_two_underflow,
  input wire logic [2:0] other_timer_stopped,
  // Status
  output logic [3:0] timers_active,
  output logic timer_zero_underflow,
  output logic timer_underflow_flag,
  input wire logic underflow_flag_clr
);
  import tsc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // Asynchronous assert, synchronous release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_ctl;
  logic [3:0] wmask;
  logic [3:0] wrun;

  assign wr_ctl = reg_req.wr && (reg_req.addr == OFS_RUN_CTL);
  assign wmask = reg_req.wdata[3:0];
  assign wrun = reg_req.wdata[7:RUN_BIT_LSB];

  tsc_cfg_t cfg_r;
  logic [7:0] rld_hi_r;
  logic [7:0] rld_lo_r;
  logic [15:0] reload;

  assign reload = {rld_hi_r, rld_lo_r};

  // Config and reload bytes; reload feeds start events and the reload at zero
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r <= tsc_cfg_t'(CFG_RESET);
      rld_hi_r <= RLD_RESET;
      rld_lo_r <= RLD_RESET;
    end else if (reg_req.wr) begin
      if (reg_req.addr == OFS_T0_CFG)
        cfg_r <= tsc_cfg_t'(reg_req.wdata & CFG_RW_MASK);
      if (reg_req.addr == OFS_T0_RLD_HI)
        rld_hi_r <= reg_req.wdata;
      if (reg_req.addr == OFS_T0_RLD_LO)
        rld_lo_r <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  logic [5:0] presc_r;
  logic tick;

  // Free-running divider; a started timer may wait up to 64 cycles
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      presc_r <= 6'h00;
    else
      presc_r <= presc_r + 6'h01;
  end

  always_comb begin
    case (cfg_r.tick_source_select)
      TICK_BASE: tick = 1'b1;
      TICK_DIV64: tick = (presc_r == PRESC_LAST);
      TICK_T2_UF: tick = timer_two_underflow;
      TICK_T1_UF: tick = timer_one_underflow;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // First timer
  // ----------------------------------------------------------------
  tsc_t0_state_t state_r;
  tsc_t0_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic running;
  logic trim;
  logic start_sw;
  logic stop_sw;
  logic hw_start;
  logic hw_stop;
  logic at_zero;
  logic uf_evt;

  assign running = (state_r == T0_RUN);
  assign trim = cfg_r.auto_start_mode[1];
  assign start_sw = wr_ctl && wmask[0] && wrun[0];
  assign stop_sw = wr_ctl && wmask[0] && !wrun[0];
  assign at_zero = (cnt_r == 16'h0000);

  // Trimming starts on a rising edge while idle
  assign hw_start = ((cfg_r.auto_start_mode == START_TX_END) && tx_end)
    || (trim && !running && lfo_rise);
  // Trimming stops on the next rising edge; receive stop only off trim
  assign hw_stop = running && ((trim && lfo_rise)
    || (!trim && cfg_r.stop_on_first_rx_bits && rx_first_bits));

  // Host writes win over link events, starts win over stops
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    uf_evt = 1'b0;
    if (start_sw) begin
      state_nxt = T0_RUN;
      cnt_nxt = reload;
    end else if (stop_sw) begin
      state_nxt = T0_IDLE;
    end else if (hw_start) begin
      state_nxt = T0_RUN;
      cnt_nxt = reload;
    end else if (hw_stop) begin
      state_nxt = T0_IDLE;
    end else if (running && tick) begin
      if (!at_zero) begin
        cnt_nxt = cnt_r - 16'h0001;
      end else if (cfg_r.auto_start_mode != START_TRIM_NO_UF) begin
        uf_evt = 1'b1;
        if (cfg_r.reload_on_zero)
          cnt_nxt = reload;
        else
          state_nxt = T0_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= T0_IDLE;
      cnt_r <= CNT_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Underflow pulse for cascading and sticky flag; a set beats a clear
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      timer_zero_underflow <= 1'b0;
      timer_underflow_flag <= 1'b0;
    end else begin
      timer_zero_underflow <= uf_evt;
      timer_underflow_flag <= uf_evt || (timer_underflow_flag && !underflow_flag_clr);
    end
  end

  // ----------------------------------------------------------------
  // Running bits of the other timers
  // ----------------------------------------------------------------
  logic [3:1] other_run_r;

  // Other timers only report through their stop input
  generate
    for (genvar i = 1; i < 4; i++) begin : g_other
      always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r)
          other_run_r[i] <= 1'b0;
        else if (wr_ctl && wmask[i])
          other_run_r[i] <= wrun[i];
        else if (other_timer_stopped[i-1])
          other_run_r[i] <= 1'b0;
      end
    end
  endgenerate

  // Registered copy of the live running state
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      timers_active <= 4'h0;
    else
      timers_active <= {other_run_r[3:1] & ~other_timer_stopped, running};
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Counter bytes are sampled live; they may be torn during reception
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_RUN_CTL: reg_rdata <= {other_run_r[3:1], running, 4'h0};
        OFS_T0_CFG: reg_rdata <= cfg_r;
        OFS_T0_RLD_HI: reg_rdata <= rld_hi_r;
        OFS_T0_RLD_LO: reg_rdata <= rld_lo_r;
        OFS_T0_CNT_HI: reg_rdata <= cnt_r[15:8];
        OFS_T0_CNT_LO: reg_rdata <= cnt_r[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_r);

  property p_mask_hold;
    wr_ctl && !wmask[1] && !other_timer_stopped[0] |=> $stable(other_run_r[1]);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("masked-off bit changed");

  property p_all_on;
    wr_ctl && reg_req.wdata == 8'hff |=> running && other_run_r == 3'h7 ##1 timers_active[0];
  endproperty
  a_all_on: assert property (p_all_on) else $error("ff write did not start all");

  property p_start;
    start_sw |=> running && cnt_r == $past(reload);
  endproperty
  a_start: assert property (p_start) else $error("start did not load reload");

  property p_stop;
    stop_sw |=> !running ##1 !timers_active[0];
  endproperty
  a_stop: assert property (p_stop) else $error("stop not applied");

  property p_rx_stop;
    running && !wr_ctl && !hw_start && !trim && cfg_r.stop_on_first_rx_bits
      && rx_first_bits |=> !running;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx did not stop timer");

  property p_trim_rx;
    running && trim && !wr_ctl && !lfo_rise && !tick && rx_first_bits |=> running;
  endproperty
  a_trim_rx: assert property (p_trim_rx) else $error("rx stopped trimming timer");

  property p_restart;
    uf_evt && cfg_r.reload_on_zero |=> running && cnt_r == $past(reload);
  endproperty
  a_restart: assert property (p_restart) else $error("no reload at zero");

  property p_zero_stop;
    uf_evt && !cfg_r.reload_on_zero |=> !running;
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("timer ran past zero");

  property p_flag;
    uf_evt |=> timer_underflow_flag && timer_zero_underflow;
  endproperty
  a_flag: assert property (p_flag) else $error("underflow flag not set");

  property p_dec;
    running && tick && !at_zero && !wr_ctl && !hw_start && !hw_stop
      |=> cnt_r == $past(cnt_r) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not decrement");

  property p_rd_hi;
    reg_req.rd && reg_req.addr == OFS_T0_CNT_HI |=> reg_rdata == $past(cnt_r[15:8]);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("count high read wrong");

  property p_rd_lo;
    reg_req.rd && reg_req.addr == OFS_T0_CNT_LO |=> reg_rdata == $past(cnt_r[7:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("count low read wrong");

  property p_cfg_rd;
    reg_req.rd && reg_req.addr == OFS_T0_CFG |=> !reg_rdata[6] && !reg_rdata[2];
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("reserved config bit read as one");

  property p_ctl_rd;
    reg_req.rd && reg_req.addr == OFS_RUN_CTL |=> reg_rdata[3:0] == 4'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("mask bits read as one");

  property p_tx_start;
    tx_end && cfg_r.auto_start_mode == START_TX_END && !wr_ctl
      |=> running && cnt_r == $past(reload);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx end did not start");

  property p_trim_hold;
    running && cfg_r.auto_start_mode == START_TRIM_NO_UF && at_zero && !wr_ctl && !lfo_rise
      |=> running && at_zero && !timer_zero_underflow;
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim hold broken");

  property p_div_tick;
    running && cfg_r.tick_source_select == TICK_DIV64 && presc_r != PRESC_LAST
      && !wr_ctl && !hw_start && !hw_stop |=> $stable(cnt_r);
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("early divided tick");

  property p_cascade;
    running && cfg_r.tick_source_select == TICK_T2_UF && !timer_two_underflow
      && !wr_ctl && !hw_start && !hw_stop |=> $stable(cnt_r);
  endproperty
  a_cascade: assert property (p_cascade) else $error("no cascade pulse");

  c_underflow: cover property (uf_evt ##1 running);
  c_div_tick: cover property (cfg_r.tick_source_select == TICK_DIV64 && tick && running);
  c_tx_start: cover property (tx_end && cfg_r.auto_start_mode == START_TX_END);
  c_trim: cover property (trim && lfo_rise && running);

endmodule

`default_nettype wire

// >>> verif/tsc_timer_section_tb.sv
// Self-checking bench for the timer section control block
`timescale 1ns/1ps
`default_nettype none

module tsc_timer_section_tb;
  import tsc_pkg::*;

  // --------
  // Signals
  // --------
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  tsc_reg_req_t req = '0;
  logic [7:0] reg_rdata;
  logic tx_end = 1'b0, rx_bits = 1'b0, lfo_rise = 1'b0;
  logic t1_uf = 1'b0, t2_uf = 1'b0, flag_clr = 1'b0;
  logic [2:0] ots = 3'h0;
  logic [3:0] timers_active;
  logic t0_uf, uf_flag;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [15:0] rl;
  logic [3:0] run;
  logic [7:0] d;
  int mismatches = 0;
  int total_checks = 0;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  tsc_timer_section i_tsc_timer_section (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(reg_rdata),
    .tx_end(tx_end), .rx_first_bits(rx_bits), .lfo_rise(lfo_rise),
    .timer_one_underflow(t1_uf), .timer_two_underflow(t2_uf),
    .other_timer_stopped(ots), .timers_active(timers_active),
    .timer_zero_underflow(t0_uf), .timer_underflow_flag(uf_flag),
    .underflow_flag_clr(flag_clr)
  );

  // --------
  // Tasks
  // --------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Strobes drop for a full cycle so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req.addr = a;
    req.wdata = v;
    req.wr = 1'b1;
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    req.addr = a;
    req.rd = 1'b1;
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
  endtask

  task automatic pl(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask

  task automatic setrl(input logic [15:0] v);
    wr(OFS_T0_RLD_HI, v[15:8]);
    wr(OFS_T0_RLD_LO, v[7:0]);
  endtask

  task automatic rdc(input logic [15:0] e); // Only used with no receive pulse
    rd(OFS_T0_CNT_HI, e[15:8]);
    rd(OFS_T0_CNT_LO, e[7:0]);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Read data lands one cycle after the strobe; oldest note is matched
  always @(posedge sys_clk) rd_q <= req.rd;
  always @(negedge sys_clk) begin
    if (rd_q) chk("rdata", exp_q.pop_front(), reg_rdata);
  end

  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    cyc(20000);
    mismatches++;
    end_of_test();
  end

  // --------
  // Sequence
  // --------
  initial begin
    rl = 16'($urandom(32'h5a39));
    rl = 16'($urandom) | 16'h0100;
    cyc(2);
    arst_n = 1'b1;
    cyc(3);
    // Reset values, then an unmapped place that must ignore writes
    for (int a = 8'h0e; a <= 8'h13; a++) rd(8'(a), 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(OFS_T0_CFG, 8'hff);
    rd(OFS_T0_CFG, 8'hbb);
    // Cascade tick keeps timer 0 frozen while run bits are shuffled
    wr(OFS_T0_CFG, 8'h03);
    wr(OFS_RUN_CTL, 8'hf0);
    rd(OFS_RUN_CTL, 8'h00);
    wr(OFS_RUN_CTL, 8'hff);
    rd(OFS_RUN_CTL, 8'hf0);
    ots = 3'b010;
    cyc(1);
    ots = 3'b000;
    cyc(1);
    rd(OFS_RUN_CTL, 8'hb0);
    chk("active", 8'h0b, {4'h0, timers_active});
    run = 4'hb;
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      run = (run & ~d[3:0]) | (d[7:4] & d[3:0]);
      wr(OFS_RUN_CTL, d);
      rd(OFS_RUN_CTL, {run, 4'h0});
      chk("active", {4'h0, run}, {4'h0, timers_active});
    end
    wr(OFS_RUN_CTL, 8'h0f);
    // Load on start, then each cascade source counts only its own pulse
    setrl(rl);
    for (int s = 2; s < 4; s++) begin
      wr(OFS_T0_CFG, 8'(s));
      wr(OFS_RUN_CTL, 8'h11);
      rdc(rl);
      pl(t1_uf);
      pl(t2_uf);
      rdc(rl - 16'd1);
    end
    setrl(~rl);
    rdc(rl - 16'd1);
    pl(t1_uf);
    rdc(rl - 16'd2);
    wr(OFS_RUN_CTL, 8'h11);
    rdc(~rl);
    // Every start mode with stop-on-receive set
    for (int m = 0; m < 4; m++) begin
      wr(OFS_RUN_CTL, 8'h01);
      wr(OFS_T0_CFG, 8'h83 | 8'(m << 4));
      pl(tx_end);
      rd(OFS_RUN_CTL, (m == 1) ? 8'h10 : 8'h00);
      if (m >= 2) begin
        pl(lfo_rise);
        rd(OFS_RUN_CTL, 8'h10);
        rdc(~rl);
      end
      pl(rx_bits);
      rd(OFS_RUN_CTL, (m >= 2) ? 8'h10 : 8'h00);
      if (m >= 2) begin
        pl(lfo_rise);
        rd(OFS_RUN_CTL, 8'h00);
      end
    end
    wr(OFS_T0_CFG, 8'h03);
    wr(OFS_RUN_CTL, 8'h11);
    pl(rx_bits);
    rd(OFS_RUN_CTL, 8'h10);
    // Short count at the base tick: stop at zero, flag, clear
    setrl(16'h0002);
    wr(OFS_T0_CFG, 8'h00);
    wr(OFS_RUN_CTL, 8'h11);
    cyc(2);
    chk("uf_pulse", 8'h01, {7'h0, t0_uf});
    chk("active", 8'h01, {4'h0, timers_active});
    cyc(4);
    chk("flag", 8'h01, {7'h0, uf_flag});
    chk("active", 8'h00, {4'h0, timers_active});
    chk("uf_pulse", 8'h00, {7'h0, t0_uf});
    rd(OFS_RUN_CTL, 8'h00);
    pl(flag_clr);
    chk("flag", 8'h00, {7'h0, uf_flag});
    // Reload on zero keeps the timer running
    wr(OFS_T0_CFG, 8'h08);
    wr(OFS_RUN_CTL, 8'h11);
    cyc(2);
    chk("uf_pulse", 8'h01, {7'h0, t0_uf});
    cyc(10);
    rd(OFS_RUN_CTL, 8'h10);
    chk("flag", 8'h01, {7'h0, uf_flag});
    wr(OFS_RUN_CTL, 8'h01);
    cyc(2);
    // Trimming without underflow parks at zero; with underflow it stops
    pl(flag_clr);
    wr(OFS_T0_CFG, 8'h20);
    pl(lfo_rise);
    cyc(4);
    rdc(16'h0000);
    chk("flag", 8'h00, {7'h0, uf_flag});
    rd(OFS_RUN_CTL, 8'h10);
    pl(lfo_rise);
    rd(OFS_RUN_CTL, 8'h00);
    wr(OFS_T0_CFG, 8'h30);
    pl(lfo_rise);
    cyc(4);
    rd(OFS_RUN_CTL, 8'h00);
    chk("flag", 8'h01, {7'h0, uf_flag});
    // Divided tick: three ticks need between 129 and 192 cycles
    pl(flag_clr);
    wr(OFS_T0_CFG, 8'h01);
    wr(OFS_RUN_CTL, 8'h11);
    cyc(100);
    rd(OFS_RUN_CTL, 8'h10);
    cyc(100);
    rd(OFS_RUN_CTL, 8'h00);
    chk("flag", 8'h01, {7'h0, uf_flag});
    end_of_test();
  end
endmodule

`default_nettype wire
